// file: rtl/supply_startup_consts.svh
// Behaviour
// - the start-up cell stays on while the supply is below the deactivation level.
// - when the supply rises above the turn-on level the start-up cell turns off and initialisation begins.
// - after initialisation, gate drive stays off until line brown-in is reached, then switching starts.
// - bang-bang supply keeping is entered while awaiting brown-in, from brown-in, fast or slow brown-out protection.
// - on brown-out the block sleeps at once and turns the start-up cell on to recharge to the turn-on level.
// - each time the supply reaches the turn-on level during brown-in search, a probe window checks for brown-in.
// - a probe window that ends without brown-in returns to sleep and resumes recharging.
// - brown-in arising during sleep is only recognised at the next wake-up after the turn-on level.
// - in protection the start-up cell turns off at the turn-on level and back on after the base delay.
// - in auto-restart the charge cycles are counted and a restart starts when the step count is reached.
// - latched protection holds until hardware reset, which is the supply falling below the deactivation level.
// - in burst, power saving is entered when feedback falls below the wake/sleep level and left when it rises.
// - in burst power saving, the start-up cell turns on when the supply drops below the sleep recharge level.
// - burst recharge stops on feedback wake-up or when the supply exceeds the turn-on level.
// - each entry into burst starts exactly one start-up cell charge cycle.
`ifndef SUPPLY_STARTUP_CONSTS_SVH
`define SUPPLY_STARTUP_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS      10
`define INIT_TIME_NS       200
`define INIT_CYCLES        ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W            16
`define PROBE_RESET        16'h0400
`define DELAY_RESET        16'h1000
`define STEP_W             8
`define STEP_RESET         8'h08
`define FLAG_COUNT         9

// ****************************************
// synchroniser vector positions
// ****************************************
`define F_ABOVE_OFF        0
`define F_ABOVE_ON         1
`define F_BELOW_SLP        2
`define F_BROWNIN          3
`define F_BO_FAST          4
`define F_BO_SLOW          5
`define F_FB_ABOVE         6
`define F_BURST_REQ        7
`define F_PROT             8

`endif

// file: rtl/supply_startup_pkg.sv
package supply_startup_pkg;

    typedef enum logic [3:0] {
        ST_CHARGE   = 4'b0000,
        ST_INIT     = 4'b0001,
        ST_WAIT_BI  = 4'b0011,
        ST_RUN      = 4'b0010,
        ST_BURST_WK = 4'b0110,
        ST_BURST_PS = 4'b0111,
        ST_BB_SLEEP = 4'b0101,
        ST_BB_PROBE = 4'b0100,
        ST_PR_CHG   = 4'b1100,
        ST_PR_WAIT  = 4'b1101,
        ST_LATCHED  = 4'b1111
    } seq_state_type;

    typedef enum logic [1:0] {
        PROT_NONE    = 2'b00,
        PROT_LATCH   = 2'b01,
        PROT_RESTART = 2'b10
    } prot_mode_type;

endpackage

// file: rtl/flag_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser; the output changes only once stages two and three agree
module flag_sync (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= 1'b0;
            s2_q   <= 1'b0;
            s3_q   <= 1'b0;
        end else begin
            meta_q <= async_in;
            s2_q   <= meta_q;
            s3_q   <= s2_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_out <= 1'b0;
        end else if (s2_q == s3_q) begin
            sync_out <= s3_q;
        end
    end
endmodule

// file: rtl/down_timer.sv
`timescale 1ns/100ps
`include "supply_startup_consts.svh"
// loadable down counter; done pulses one cycle when the count runs out
module down_timer (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  load,
    input  wire logic [`TIMER_W-1:0]   length,
    output logic                       running,
    output logic                       done
);
    logic [`TIMER_W-1:0] count_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            count_q <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end else if (load) begin
            count_q <= (length == '0) ? `TIMER_W'(1) : length;
            running <= 1'b1;
            done    <= 1'b0;
        end else if (running) begin
            count_q <= count_q - `TIMER_W'(1);
            done    <= (count_q == `TIMER_W'(1));
            running <= (count_q != `TIMER_W'(1));
        end else begin
            done <= 1'b0;
        end
    end
endmodule

// file: rtl/supply_startup_sequencer.sv
`timescale 1ns/100ps
`include "supply_startup_consts.svh"

// ****************************************
// supply start-up and activity sequencer
// ****************************************
module supply_startup_sequencer
    import supply_startup_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // comparator flags, asynchronous to mclk
    input  wire logic                 supply_above_deactivation,
    input  wire logic                 supply_above_turn_on,
    input  wire logic                 supply_below_sleep_recharge,
    input  wire logic                 line_brownin,
    input  wire logic                 brownout_fast,
    input  wire logic                 brownout_slow,
    input  wire logic                 feedback_above_burst_level,
    input  wire logic                 burst_request,
    input  wire logic                 protection_trigger,
    // configuration
    input  wire logic [1:0]           protection_mode,
    input  wire logic [`TIMER_W-1:0]  brownin_probe_window,
    input  wire logic [`TIMER_W-1:0]  restart_recharge_delay,
    input  wire logic [`STEP_W-1:0]   restart_cycle_count,
    // register port
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata,
    // outputs
    output logic                      startup_cell_on,
    output logic                      gate_drive_enable,
    output logic                      low_power_sleep,
    output logic                      restart_pulse,
    output logic [3:0]                seq_state,
    output logic                      irq
);

    // ****************************************
    // input synchronisation
    // ****************************************
    logic [`FLAG_COUNT-1:0] raw_flags;
    logic [`FLAG_COUNT-1:0] flags;

    assign raw_flags[`F_ABOVE_OFF] = supply_above_deactivation;
    assign raw_flags[`F_ABOVE_ON]  = supply_above_turn_on;
    assign raw_flags[`F_BELOW_SLP] = supply_below_sleep_recharge;
    assign raw_flags[`F_BROWNIN]   = line_brownin;
    assign raw_flags[`F_BO_FAST]   = brownout_fast;
    assign raw_flags[`F_BO_SLOW]   = brownout_slow;
    assign raw_flags[`F_FB_ABOVE]  = feedback_above_burst_level;
    assign raw_flags[`F_BURST_REQ] = burst_request;
    assign raw_flags[`F_PROT]      = protection_trigger;

    genvar gi;
    generate
        for (gi = 0; gi < `FLAG_COUNT; gi = gi + 1) begin : g_sync
            flag_sync u_sync (
                .mclk     (mclk),
                .rst      (rst),
                .async_in (raw_flags[gi]),
                .sync_out (flags[gi])
            );
        end
    endgenerate

    logic above_off;
    logic above_on;
    logic below_slp;
    logic brownin;
    logic brownout;
    logic fb_above;
    logic burst_req;
    logic prot;

    assign above_off = flags[`F_ABOVE_OFF];
    assign above_on  = flags[`F_ABOVE_ON];
    assign below_slp = flags[`F_BELOW_SLP];
    assign brownin   = flags[`F_BROWNIN];
    assign brownout  = flags[`F_BO_FAST] | flags[`F_BO_SLOW];
    assign fb_above  = flags[`F_FB_ABOVE];
    assign burst_req = flags[`F_BURST_REQ];
    assign prot      = flags[`F_PROT];

    // supply falling below the deactivation level acts as a hardware reset
    logic hw_rst;
    assign hw_rst = rst | ~above_off;

    // ****************************************
    // timers
    // ****************************************
    logic probe_load;
    logic probe_run;
    logic probe_done;
    logic delay_load;
    logic delay_run;
    logic delay_done;
    logic init_load;
    logic init_run;
    logic init_done;

    down_timer u_probe (
        .mclk    (mclk),
        .rst     (hw_rst),
        .load    (probe_load),
        .length  (brownin_probe_window),
        .running (probe_run),
        .done    (probe_done)
    );

    down_timer u_delay (
        .mclk    (mclk),
        .rst     (hw_rst),
        .load    (delay_load),
        .length  (restart_recharge_delay),
        .running (delay_run),
        .done    (delay_done)
    );

    down_timer u_init (
        .mclk    (mclk),
        .rst     (hw_rst),
        .load    (init_load),
        .length  (`TIMER_W'(`INIT_CYCLES)),
        .running (init_run),
        .done    (init_done)
    );

    // ****************************************
    // state machine
    // ****************************************
    seq_state_type         state_q;
    seq_state_type         state_d;
    logic [`STEP_W-1:0]    steps_q;
    logic                  burst_charge_q;
    logic                  restart_go;

    assign restart_go = (prot_mode_type'(protection_mode) == PROT_RESTART)
                        && (steps_q >= restart_cycle_count)
                        && (restart_cycle_count != '0);

    always_comb begin
        state_d    = state_q;
        probe_load = 1'b0;
        delay_load = 1'b0;
        init_load  = 1'b0;
        case (state_q)
            ST_CHARGE: begin
                if (above_on) begin
                    state_d   = ST_INIT;
                    init_load = 1'b1;
                end
            end
            ST_INIT: begin
                if (init_done) begin
                    state_d = ST_WAIT_BI;
                end
            end
            ST_WAIT_BI: begin
                if (brownin) begin
                    state_d = ST_RUN;
                end else begin
                    state_d = ST_BB_SLEEP;
                end
            end
            ST_RUN, ST_BURST_WK, ST_BURST_PS: begin
                if (prot && prot_mode_type'(protection_mode) != PROT_NONE) begin
                    state_d = ST_PR_CHG;
                end else if (brownout) begin
                    state_d = ST_BB_SLEEP;
                end else if (state_q == ST_RUN) begin
                    if (burst_req) begin
                        state_d = ST_BURST_WK;
                    end
                end else if (!burst_req) begin
                    state_d = ST_RUN;
                end else if (state_q == ST_BURST_WK && !fb_above) begin
                    state_d = ST_BURST_PS;
                end else if (state_q == ST_BURST_PS && fb_above) begin
                    state_d = ST_BURST_WK;
                end
            end
            ST_BB_SLEEP: begin
                if (above_on) begin
                    state_d    = ST_BB_PROBE;
                    probe_load = 1'b1;
                end
            end
            ST_BB_PROBE: begin
                if (brownin) begin
                    state_d = ST_RUN;
                end else if (probe_done) begin
                    state_d = ST_BB_SLEEP;
                end
            end
            ST_PR_CHG: begin
                if (above_on) begin
                    state_d    = ST_PR_WAIT;
                    delay_load = 1'b1;
                end
            end
            ST_PR_WAIT: begin
                if (restart_go) begin
                    state_d = ST_CHARGE;
                end else if (delay_done) begin
                    state_d = ST_PR_CHG;
                end
            end
            default: begin
                state_d = ST_CHARGE;
            end
        endcase
        // latched protection never returns to charge-up until the supply collapses
        if (state_q == ST_PR_CHG || state_q == ST_PR_WAIT) begin
            if (prot_mode_type'(protection_mode) == PROT_LATCH && state_d == ST_CHARGE) begin
                state_d = state_q;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (hw_rst) begin
            state_q <= ST_CHARGE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // restart cycle counter
    // ****************************************
    always_ff @(posedge mclk) begin
        if (hw_rst) begin
            steps_q <= '0;
        end else if (state_q != ST_PR_CHG && state_q != ST_PR_WAIT) begin
            steps_q <= '0;
        end else if (state_q == ST_PR_CHG && state_d == ST_PR_WAIT && steps_q != '1) begin
            steps_q <= steps_q + `STEP_W'(1);
        end
    end

    // ****************************************
    // burst recharge: one charge cycle at entry, then on low supply
    // ****************************************
    always_ff @(posedge mclk) begin
        if (hw_rst) begin
            burst_charge_q <= 1'b0;
        end else if (state_q == ST_RUN && state_d == ST_BURST_WK) begin
            burst_charge_q <= 1'b1;
        end else if (state_d != ST_BURST_WK && state_d != ST_BURST_PS) begin
            burst_charge_q <= 1'b0;
        end else if (above_on) begin
            burst_charge_q <= 1'b0;
        end else if (state_q == ST_BURST_PS && state_d == ST_BURST_WK) begin
            burst_charge_q <= 1'b0;
        end else if (state_d == ST_BURST_PS && below_slp) begin
            burst_charge_q <= 1'b1;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge mclk) begin
        if (hw_rst) begin
            startup_cell_on   <= 1'b1;
            gate_drive_enable <= 1'b0;
            low_power_sleep   <= 1'b0;
            seq_state         <= 4'h0;
        end else begin
            case (state_d)
                ST_CHARGE, ST_BB_SLEEP, ST_PR_CHG: startup_cell_on <= 1'b1;
                ST_BURST_WK, ST_BURST_PS:          startup_cell_on <= burst_charge_q;
                default:                           startup_cell_on <= 1'b0;
            endcase
            gate_drive_enable <= (state_d == ST_RUN) || (state_d == ST_BURST_WK);
            low_power_sleep   <= (state_d == ST_BB_SLEEP) || (state_d == ST_BURST_PS)
                                 || (state_d == ST_PR_CHG) || (state_d == ST_PR_WAIT);
            seq_state         <= state_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (hw_rst) begin
            restart_pulse <= 1'b0;
        end else begin
            restart_pulse <= (state_q == ST_PR_WAIT) && restart_go;
        end
    end

    // ****************************************
    // event status, mask, read port
    // ****************************************
    logic [4:0] events;
    logic [4:0] status_q;
    logic [4:0] mask_q;

    assign events = {restart_pulse,
                     state_q != ST_PR_CHG && state_d == ST_PR_CHG && state_q != ST_PR_WAIT,
                     state_q != ST_BURST_WK && state_q != ST_BURST_PS && state_d == ST_BURST_WK,
                     state_q != ST_RUN && state_d == ST_RUN && state_q != ST_BURST_WK && state_q != ST_BURST_PS,
                     state_q != ST_BB_SLEEP && state_q != ST_BB_PROBE && state_d == ST_BB_SLEEP};

    // a new event wins over the clearing read
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_q <= '0;
        end else if (reg_rd && reg_addr == 4'h0) begin
            status_q <= events;
        end else begin
            status_q <= status_q | events;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mask_q <= '0;
        end else if (reg_wr && reg_addr == 4'h4) begin
            mask_q <= reg_wdata[4:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0;
        end else if (reg_addr == 4'h0) begin
            reg_rdata <= {27'h0, status_q};
        end else if (reg_addr == 4'h4) begin
            reg_rdata <= {27'h0, mask_q};
        end else if (reg_addr == 4'h8) begin
            reg_rdata <= {16'h0, steps_q, 4'h0, state_q};
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((reg_rd && reg_addr == 4'h0) ? events : (status_q | events)) & mask_q);
        end
    end

endmodule

// file: verif/supply_startup_sequencer_properties.sv
`timescale 1ns/100ps
module supply_startup_sequencer_properties
    import supply_startup_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [1:0] protection_mode,
    input wire logic       startup_cell_on,
    input wire logic       gate_drive_enable,
    input wire logic       low_power_sleep,
    input wire logic       restart_pulse,
    input wire logic [3:0] seq_state
);
    // ****************************************
    // sequencer properties
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    reset_home_a: assert property (
        $fell(rst) |-> seq_state == ST_CHARGE && startup_cell_on && !gate_drive_enable && !restart_pulse)
        else $error("sequencer not at charge-up after reset");
    charge_cell_on_a: assert property (seq_state == ST_CHARGE |-> startup_cell_on)
        else $error("start-up cell off during charge-up");
    init_cell_off_a: assert property (
        seq_state == ST_INIT |-> !startup_cell_on && !gate_drive_enable)
        else $error("start-up cell or drive on during initialisation");
    // initialisation lasts a fixed span, never a single cycle and never forever
    init_span_a: assert property (
        $rose(seq_state == ST_INIT) |-> (seq_state == ST_INIT)[*8] ##[1:20] (seq_state != ST_INIT))
        else $error("initialisation span wrong");
    gate_run_a: assert property (
        gate_drive_enable |-> seq_state inside {ST_RUN, ST_BURST_WK})
        else $error("gate drive enabled outside run");
    sleep_recharge_a: assert property (
        seq_state == ST_BB_SLEEP |-> low_power_sleep && startup_cell_on && !gate_drive_enable)
        else $error("brown-in sleep outputs wrong");
    probe_awake_a: assert property (
        seq_state == ST_BB_PROBE |-> !low_power_sleep && !startup_cell_on)
        else $error("probe window outputs wrong");
    sleep_no_run_a: assert property (
        seq_state == ST_BB_SLEEP ##1 seq_state != ST_BB_SLEEP |-> seq_state != ST_RUN)
        else $error("run entered straight from sleep");
    latch_exit_a: assert property (
        protection_mode == PROT_LATCH && seq_state inside {ST_PR_CHG, ST_PR_WAIT}
        |=> seq_state inside {ST_PR_CHG, ST_PR_WAIT, ST_CHARGE})
        else $error("latched protection left other than by collapse");
    burst_ps_sleep_a: assert property (
        seq_state == ST_BURST_PS |-> low_power_sleep && !gate_drive_enable)
        else $error("burst power saving outputs wrong");
    restart_pulse_a: assert property (
        restart_pulse |-> protection_mode == PROT_RESTART ##1 !restart_pulse)
        else $error("restart pulse wrong");

    run_seen_c: cover property (seq_state == ST_RUN);
    probe_seen_c: cover property (seq_state == ST_BB_PROBE);
    burst_charge_c: cover property (seq_state == ST_BURST_PS && startup_cell_on);
    restart_seen_c: cover property (restart_pulse);
endmodule

// file: verif/supply_startup_sequencer_tb_top.sv
`timescale 1ns/100ps
module supply_startup_sequencer_tb_top
    import supply_startup_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        supply_above_deactivation = 1'b0;
    logic        supply_above_turn_on = 1'b0;
    logic        supply_below_sleep_recharge = 1'b0;
    logic        line_brownin = 1'b0;
    logic        brownout_fast = 1'b0;
    logic        brownout_slow = 1'b0;
    logic        feedback_above_burst_level = 1'b0;
    logic        burst_request = 1'b0;
    logic        protection_trigger = 1'b0;
    logic [1:0]  protection_mode = 2'h0;
    logic [15:0] brownin_probe_window = 16'h0008;
    logic [15:0] restart_recharge_delay = 16'h0008;
    logic [7:0]  restart_cycle_count = 8'h02;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        startup_cell_on;
    logic        gate_drive_enable;
    logic        low_power_sleep;
    logic        restart_pulse;
    logic [3:0]  seq_state;
    logic        irq;
    int          mismatches = 0;
    int          cmp_count = 0;

    always #5 mclk = ~mclk;

    supply_startup_sequencer DUT (.mclk, .rst, .supply_above_deactivation, .supply_above_turn_on,
        .supply_below_sleep_recharge, .line_brownin, .brownout_fast, .brownout_slow,
        .feedback_above_burst_level, .burst_request, .protection_trigger, .protection_mode,
        .brownin_probe_window, .restart_recharge_delay, .restart_cycle_count, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .startup_cell_on, .gate_drive_enable, .low_power_sleep,
        .restart_pulse, .seq_state, .irq);

    // ****************************************
    // access and compare tasks
    // ****************************************
    task check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task wait_state(input seq_state_type st, input int lim);
        int n;
        n = 0;
        while (seq_state !== st && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check_val({28'h0, seq_state}, {28'h0, st}, "state");
    endtask

    // comparator flags need a few cycles through the synchronisers
    task settle;
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        int          n;
        logic [31:0] d;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        check_val({seq_state, startup_cell_on, gate_drive_enable}, {ST_CHARGE, 2'b10}, "reset");
        reg_write(4'h4, 32'h1F);
        reg_read(4'h4, d);
        check_val(d, 32'h1F, "mask");
        reg_read(4'hC, d);
        check_val(d, 32'h0, "unmapped");
        @(posedge mclk);
        supply_above_deactivation <= 1'b1;
        supply_above_turn_on      <= 1'b1;
        wait_state(ST_INIT, 20);
        check_val({31'h0, startup_cell_on}, 32'h0, "cell init");
        @(posedge mclk);
        supply_above_turn_on <= 1'b0;
        wait_state(ST_BB_SLEEP, 60);
        check_val({low_power_sleep, startup_cell_on, gate_drive_enable}, 3'b110, "sleep");
        @(posedge mclk);
        supply_above_turn_on <= 1'b1;
        wait_state(ST_BB_PROBE, 20);
        @(posedge mclk);
        supply_above_turn_on <= 1'b0;
        wait_state(ST_BB_SLEEP, 30);
        @(posedge mclk);
        line_brownin <= 1'b1;
        repeat (20) @(posedge mclk);
        #1;
        check_val({seq_state, gate_drive_enable}, {ST_BB_SLEEP, 1'b0}, "asleep");
        @(posedge mclk);
        supply_above_turn_on <= 1'b1;
        wait_state(ST_RUN, 40);
        check_val({gate_drive_enable, irq}, 2'b11, "run");
        reg_read(4'h8, d);
        check_val({28'h0, d[3:0]}, {28'h0, ST_RUN}, "state reg");
        reg_read(4'h0, d);
        check_val(d & 32'h3, 32'h3, "status");
        reg_read(4'h0, d);
        check_val(d | {31'h0, irq}, 32'h0, "cleared");
        for (n = 0; n < 2; n++) begin
            @(posedge mclk);
            {brownout_slow, brownout_fast} <= (n == 0) ? 2'b01 : 2'b10;
            line_brownin         <= 1'b0;
            supply_above_turn_on <= 1'b0;
            wait_state(ST_BB_SLEEP, 30);
            @(posedge mclk);
            {brownout_slow, brownout_fast} <= 2'b00;
            line_brownin         <= 1'b1;
            supply_above_turn_on <= 1'b1;
            wait_state(ST_RUN, 60);
        end
        // burst with the interrupt masked first
        reg_write(4'h4, 32'h0);
        @(posedge mclk);
        supply_above_turn_on <= 1'b0;
        burst_request        <= 1'b1;
        wait_state(ST_BURST_PS, 30);
        check_val({low_power_sleep, startup_cell_on, irq}, 3'b110, "burst entry");
        @(posedge mclk);
        supply_above_turn_on <= 1'b1;
        settle();
        check_val({31'h0, startup_cell_on}, 32'h0, "charge end");
        @(posedge mclk);
        supply_above_turn_on <= 1'b0;
        settle();
        check_val({31'h0, startup_cell_on}, 32'h0, "no recharge");
        @(posedge mclk);
        supply_below_sleep_recharge <= 1'b1;
        settle();
        check_val({31'h0, startup_cell_on}, 32'h1, "recharge");
        @(posedge mclk);
        feedback_above_burst_level <= 1'b1;
        wait_state(ST_BURST_WK, 20);
        reg_write(4'h4, 32'h1F);
        @(posedge mclk);
        #1;
        check_val({31'h0, startup_cell_on}, 32'h0, "wake");
        check_val({31'h0, irq}, 32'h1, "irq unmasked");
        reg_read(4'h0, d);
        check_val(d & 32'h4, 32'h4, "burst status");
        @(posedge mclk);
        supply_below_sleep_recharge <= 1'b0;
        burst_request               <= 1'b0;
        supply_above_turn_on        <= 1'b1;
        wait_state(ST_RUN, 30);
        // ****************************************
        // protection
        // ****************************************
        @(posedge mclk);
        protection_mode    <= 2'h2;
        protection_trigger <= 1'b1;
        repeat (6) @(posedge mclk);
        protection_trigger <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        check_val({31'h0, gate_drive_enable}, 32'h0, "prot drive");
        n = 0;
        while (restart_pulse !== 1'b1 && n < 600) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check_val({31'h0, restart_pulse}, 32'h1, "restart");
        wait_state(ST_RUN, 80);
        reg_read(4'h0, d);
        check_val(d & 32'h18, 32'h18, "prot status");
        @(posedge mclk);
        protection_mode    <= 2'h1;
        protection_trigger <= 1'b1;
        repeat (6) @(posedge mclk);
        protection_trigger <= 1'b0;
        repeat (300) @(posedge mclk);
        #1;
        check_val({seq_state == ST_RUN, gate_drive_enable, restart_pulse}, 3'b000, "latched");
        @(posedge mclk);
        supply_above_deactivation <= 1'b0;
        supply_above_turn_on      <= 1'b0;
        wait_state(ST_CHARGE, 20);
        check_val({31'h0, startup_cell_on}, 32'h1, "collapse");
        tally_and_finish();
    end

    initial begin
        #40000;
        mismatches++;
        tally_and_finish();
    end
endmodule

bind supply_startup_sequencer supply_startup_sequencer_properties chk (.mclk, .rst, .protection_mode,
    .startup_cell_on, .gate_drive_enable, .low_power_sleep, .restart_pulse, .seq_state);
